// *** hw/arb_consts.svh ***
// constants for the adc result readback port
`ifndef ARB_CONSTS_SVH
`define ARB_CONSTS_SVH

// ==========================================================
// sizes
`define ARB_NUM_CH          8
`define ARB_RES_W           16
`define ARB_CNT_W           24

// ==========================================================
// interface select codes {interface_select, byte_mode_select}
`define ARB_SEL_PARALLEL    2'h0
`define ARB_SEL_BYTE        2'h3
`define ARB_SEL_SERIAL      2'h2

// ==========================================================
// static pin positions in the synchronised pin group
`define ARB_PIN_W           8
`define ARB_PIN_IFSEL       0
`define ARB_PIN_BYTESEL     1
`define ARB_PIN_HBF         2
`define ARB_PIN_OS_LO       3
`define ARB_PIN_OS_HI       5
`define ARB_PIN_TRIG1       6
`define ARB_PIN_TRIG2       7

// ==========================================================
// control strobe positions
`define ARB_CTL_W           2
`define ARB_CTL_CS          0
`define ARB_CTL_RD          1
`define ARB_CTL_IDLE        2'h3

// ==========================================================
// reset values and timing
`define ARB_OSR_RESET       3'h0
`define ARB_CLK_PERIOD_NS   25
`define ARB_CONV_TIME_NS    2000
`define ARB_CONV_CYCLES \
  ((`ARB_CONV_TIME_NS + `ARB_CLK_PERIOD_NS - 1) / `ARB_CLK_PERIOD_NS)

`endif

// *** hw/arb_pkg.sv ***
// types for the adc result readback port
package arb_pkg;

  // ========================================================
  // conversion timer states, gray along idle -> conv
  typedef enum logic [0:0] {
    ARB_CONV_IDLE = 1'b0,
    ARB_CONV_RUN  = 1'b1
  } arb_conv_state_type;

  // ========================================================
  // readback interface modes
  typedef enum logic [1:0] {
    ARB_MODE_PARALLEL = 2'h0,
    ARB_MODE_BYTE     = 2'h1,
    ARB_MODE_SERIAL   = 2'h3
  } arb_mode_type;

endpackage : arb_pkg

// *** hw/arb_edge_if.sv ***
// synchronised pin levels and their edges
`timescale 1ns/100ps
interface arb_edge_if #(
  parameter int W = 1
);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : arb_edge_if

// *** hw/arb_sync_edge.sv ***
// two-stage pin synchroniser with edge detection
`timescale 1ns/100ps
module arb_sync_edge #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic   CLK,
  input  wire logic   RST,
  input  wire logic [W-1:0] PIN,
  arb_edge_if.src     EDGES
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // ========================================================
  // synchroniser and edge history
  always_ff @(posedge CLK) begin
    if (RST) begin
      // idle level of the pins, so release gives no false edge
      meta_reg <= INIT;
      sync_reg <= INIT;
      prev_reg <= INIT;
    end else begin
      meta_reg <= PIN;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign EDGES.level = sync_reg;
  assign EDGES.rise  = sync_reg & ~prev_reg;
  assign EDGES.fall  = ~sync_reg & prev_reg;
endmodule : arb_sync_edge

// *** hw/arb_readback.sv ***
// adc result readback port: parallel, byte and serial modes
// What this block does
// - parallel reads use chip select, read, bus, busy
// - first strobe fall presents channel one
// - first channel flag rises with channel one
// - later strobe falls present next channel
// - byte mode sends two bytes per channel
// - byte order input picks high byte first
// - bytes appear on low eight bus lines
// - serial uses select, clock, flags, two outputs
// - sixteen clocks per channel, ascending channels
// - primary line sends first group first
// - secondary line sends second group first
// - reads during busy return previous results
// - ratio inputs latched when busy falls
// - busy lengthens with oversampling ratio
// - select fall starts frame, rise floats outputs
// - result registers load when busy falls
// - serial transfers timed to clock rising edge
`timescale 1ns/100ps
`include "arb_consts.svh"
module arb_readback #(
  parameter int NUM_CH           = `ARB_NUM_CH,
  parameter int RES_W            = `ARB_RES_W,
  parameter int BASE_CONV_CYCLES = `ARB_CONV_CYCLES
) (
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic                    CS_N,
  input  wire logic                    RD_SCLK,
  input  wire logic                    INTERFACE_SELECT,
  input  wire logic                    BYTE_MODE_SELECT,
  input  wire logic                    HIGH_BYTE_FIRST_SELECT,
  input  wire logic [2:0]              OVERSAMPLING_RATIO_SELECT,
  input  wire logic                    SAMPLE_TRIGGER_GROUP1,
  input  wire logic                    SAMPLE_TRIGGER_GROUP2,
  input  wire logic [NUM_CH*RES_W-1:0] RESULT_DATA,
  output logic                         BUSY,
  output logic [2:0]                   OVERSAMPLING_RATIO,
  output logic                         FIRST_CHANNEL_FLAG,
  output logic [RES_W-1:0]             PARALLEL_OUT_BUS,
  output logic                         PARALLEL_OUT_BUS_OE_N,
  output logic                         SERIAL_OUT_PRIMARY,
  output logic                         SERIAL_OUT_SECONDARY,
  output logic                         SERIAL_OUT_OE_N
);
  localparam int PTR_W = $clog2(NUM_CH);
  localparam int CNT_W = `ARB_CNT_W;
  localparam int BIT_W = $clog2(RES_W);
  localparam logic [PTR_W-1:0] HALF = PTR_W'(NUM_CH / 2);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(RES_W - 1);

  // ========================================================
  // pin synchronisers
  arb_edge_if #(.W(`ARB_CTL_W)) ctl ();
  arb_edge_if #(.W(`ARB_PIN_W)) pin ();

  arb_sync_edge #(.W(`ARB_CTL_W), .INIT(`ARB_CTL_IDLE)) u_ctl_sync (
    .CLK   (CLK),
    .RST   (RST),
    .PIN   ({RD_SCLK, CS_N}),
    .EDGES (ctl)
  );
  arb_sync_edge #(.W(`ARB_PIN_W)) u_pin_sync (
    .CLK   (CLK),
    .RST   (RST),
    .PIN   ({SAMPLE_TRIGGER_GROUP2, SAMPLE_TRIGGER_GROUP1,
             OVERSAMPLING_RATIO_SELECT, HIGH_BYTE_FIRST_SELECT,
             BYTE_MODE_SELECT, INTERFACE_SELECT}),
    .EDGES (pin)
  );

  logic                        cs_high;
  logic                        cs_fall;
  logic                        sclk_rise;
  logic                        strobe_low;
  logic                        strobe_fall;
  logic                        hbf;
  logic [2:0]                  os_pins;
  arb_pkg::arb_mode_type       mode;

  assign cs_high   = ctl.level[`ARB_CTL_CS];
  assign cs_fall   = ctl.fall[`ARB_CTL_CS];
  assign sclk_rise = ctl.rise[`ARB_CTL_RD];
  assign hbf       = pin.level[`ARB_PIN_HBF];
  assign os_pins   = pin.level[`ARB_PIN_OS_HI:`ARB_PIN_OS_LO];
  assign strobe_low = ~ctl.level[`ARB_CTL_CS] & ~ctl.level[`ARB_CTL_RD];

  // ========================================================
  // interface mode decode
  always_comb begin
    unique case ({pin.level[`ARB_PIN_IFSEL], pin.level[`ARB_PIN_BYTESEL]})
      `ARB_SEL_BYTE:   mode = arb_pkg::ARB_MODE_BYTE;
      `ARB_SEL_SERIAL: mode = arb_pkg::ARB_MODE_SERIAL;
      default:         mode = arb_pkg::ARB_MODE_PARALLEL;
    endcase
  end

  // ========================================================
  // conversion timer and busy
  arb_pkg::arb_conv_state_type conv_state_reg;
  logic [CNT_W-1:0]            conv_cnt_reg;
  logic [2:0]                  osr_reg;
  logic                        conv_start;
  logic                        conv_done;

  assign conv_start = (pin.rise[`ARB_PIN_TRIG1] | pin.rise[`ARB_PIN_TRIG2])
                      & (conv_state_reg == arb_pkg::ARB_CONV_IDLE);
  assign conv_done  = (conv_state_reg == arb_pkg::ARB_CONV_RUN)
                      & (conv_cnt_reg == '0);

  always_ff @(posedge CLK) begin
    if (RST) begin
      conv_state_reg <= arb_pkg::ARB_CONV_IDLE;
      conv_cnt_reg   <= '0;
    end else begin
      unique case (conv_state_reg)
        arb_pkg::ARB_CONV_IDLE: begin
          if (conv_start) begin
            conv_state_reg <= arb_pkg::ARB_CONV_RUN;
            conv_cnt_reg   <= (CNT_W'(BASE_CONV_CYCLES) << osr_reg)
                              - CNT_W'(1);
          end
        end
        arb_pkg::ARB_CONV_RUN: begin
          if (conv_done) begin
            conv_state_reg <= arb_pkg::ARB_CONV_IDLE;
          end else begin
            conv_cnt_reg <= conv_cnt_reg - CNT_W'(1);
          end
        end
      endcase
    end
  end

  // latch ratio at end of conversion for the next one
  always_ff @(posedge CLK) begin
    if (RST) begin
      osr_reg <= `ARB_OSR_RESET;
    end else if (conv_done) begin
      osr_reg <= os_pins;
    end
  end

  assign BUSY               = (conv_state_reg == arb_pkg::ARB_CONV_RUN);
  assign OVERSAMPLING_RATIO = osr_reg;

  // ========================================================
  // result registers, updated only at end of conversion
  logic [RES_W-1:0] res_reg [NUM_CH];

  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_CH; i++) begin
        res_reg[i] <= '0;
      end
    end else if (conv_done) begin
      for (int i = 0; i < NUM_CH; i++) begin
        res_reg[i] <= RESULT_DATA[i*RES_W +: RES_W];
      end
    end
  end

  // ========================================================
  // parallel and byte readback
  logic              strobe_prev_reg;
  logic              first_pend_reg;
  logic              first_eff;
  logic              byte_idx_reg;
  logic [PTR_W-1:0]  ptr_reg;
  logic [PTR_W-1:0]  ptr_next;
  logic [RES_W-1:0]  bus_reg;
  logic              bus_oe_n_reg;
  logic              flag_reg;
  logic [RES_W-1:0]  sel_word;

  assign strobe_fall = strobe_low & ~strobe_prev_reg;
  assign first_eff   = first_pend_reg | cs_fall;
  assign ptr_next    = first_eff ? '0 :
                       (mode == arb_pkg::ARB_MODE_BYTE && byte_idx_reg) ?
                       ptr_reg : ptr_reg + PTR_W'(1);
  assign sel_word    = res_reg[ptr_next];

  always_ff @(posedge CLK) begin
    if (RST) begin
      strobe_prev_reg <= 1'b0;
      bus_oe_n_reg    <= 1'b1;
    end else begin
      strobe_prev_reg <= strobe_low;
      bus_oe_n_reg    <= ~(strobe_low
                           & (mode != arb_pkg::ARB_MODE_SERIAL));
    end
  end

  // ========================================================
  // serial shifters, and the parallel and byte read registers
  logic [RES_W-1:0]  shift_a_reg;
  logic [RES_W-1:0]  shift_b_reg;
  logic [BIT_W-1:0]  bit_cnt_reg;
  logic [PTR_W-1:0]  sch_reg;
  logic              ser_oe_n_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      first_pend_reg <= 1'b1;
      byte_idx_reg   <= 1'b0;
      ptr_reg        <= '0;
      bus_reg        <= '0;
      flag_reg       <= 1'b0;
      shift_a_reg    <= '0;
      shift_b_reg    <= '0;
      bit_cnt_reg    <= '0;
      sch_reg        <= '0;
      ser_oe_n_reg   <= 1'b1;
    end else begin
      ser_oe_n_reg <= ~(~cs_high & (mode == arb_pkg::ARB_MODE_SERIAL));
      if (mode == arb_pkg::ARB_MODE_SERIAL) begin
        if (cs_fall) begin
          sch_reg     <= '0;
          bit_cnt_reg <= '0;
          shift_a_reg <= res_reg[0];
          shift_b_reg <= res_reg[HALF];
          flag_reg    <= 1'b1;
        end else if (sclk_rise && !cs_high) begin
          if (bit_cnt_reg == LAST_BIT) begin
            bit_cnt_reg <= '0;
            sch_reg     <= sch_reg + PTR_W'(1);
            shift_a_reg <= res_reg[sch_reg + PTR_W'(1)];
            shift_b_reg <= res_reg[sch_reg + PTR_W'(1) + HALF];
            flag_reg    <= 1'b0;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + BIT_W'(1);
            shift_a_reg <= {shift_a_reg[RES_W-2:0], 1'b0};
            shift_b_reg <= {shift_b_reg[RES_W-2:0], 1'b0};
          end
        end
      end else begin
        if (strobe_fall) begin
          // end of conversion in the same cycle still rewinds
          first_pend_reg <= conv_done;
          ptr_reg        <= ptr_next;
          if (mode == arb_pkg::ARB_MODE_BYTE) begin
            byte_idx_reg <= first_eff ? 1'b1 : ~byte_idx_reg;
            if (first_eff || !byte_idx_reg) begin
              bus_reg <= {8'h00, hbf ? sel_word[15:8] : sel_word[7:0]};
            end else begin
              bus_reg <= {8'h00, hbf ? sel_word[7:0] : sel_word[15:8]};
            end
            flag_reg <= (ptr_next == '0);
          end else begin
            bus_reg  <= sel_word;
            flag_reg <= first_eff;
          end
        end else if (cs_fall || conv_done) begin
          first_pend_reg <= 1'b1;
        end
      end
    end
  end

  assign PARALLEL_OUT_BUS      = bus_reg;
  assign PARALLEL_OUT_BUS_OE_N = bus_oe_n_reg;
  assign FIRST_CHANNEL_FLAG    = flag_reg;
  assign SERIAL_OUT_PRIMARY    = shift_a_reg[RES_W-1];
  assign SERIAL_OUT_SECONDARY  = shift_b_reg[RES_W-1];
  assign SERIAL_OUT_OE_N       = ser_oe_n_reg;

  // ========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_FIRST_CH: assert property (
    strobe_fall && first_eff && mode == arb_pkg::ARB_MODE_PARALLEL
    |=> bus_reg == res_reg[0] && flag_reg)
    else $error("channel one not presented on first strobe");
  AST_NEXT_CH: assert property (
    strobe_fall && !first_eff && mode == arb_pkg::ARB_MODE_PARALLEL
    |=> ptr_reg == $past(ptr_reg) + PTR_W'(1) && !flag_reg)
    else $error("pointer did not advance");
  AST_BYTE_ORDER: assert property (
    strobe_fall && first_eff && hbf && mode == arb_pkg::ARB_MODE_BYTE
    |=> bus_reg[7:0] == res_reg[0][15:8] && bus_reg[15:8] == 8'h00)
    else $error("byte order wrong");
  AST_FLOAT: assert property (
    cs_high |=> bus_oe_n_reg && ser_oe_n_reg)
    else $error("outputs driven with select high");
  AST_OS_LATCH: assert property (
    conv_done |=> osr_reg == $past(os_pins))
    else $error("ratio not latched at busy fall");
  AST_BUSY_MIN: assert property (
    conv_start |=> BUSY [*8])
    else $error("busy too short");
  AST_BUSY_LEN: assert property (
    conv_start |=> conv_cnt_reg ==
      (CNT_W'(BASE_CONV_CYCLES) << $past(osr_reg)) - CNT_W'(1))
    else $error("busy length not scaled by ratio");
  AST_LOAD: assert property (
    $fell(BUSY) |-> res_reg[NUM_CH-1] ==
      $past(RESULT_DATA[NUM_CH*RES_W-1 -: RES_W]))
    else $error("results not loaded at busy fall");
  AST_SER_LOAD: assert property (
    cs_fall && mode == arb_pkg::ARB_MODE_SERIAL
    |=> shift_a_reg == res_reg[0] && shift_b_reg == res_reg[HALF])
    else $error("serial groups loaded wrong");
  AST_SER_SHIFT: assert property (
    mode == arb_pkg::ARB_MODE_SERIAL && sclk_rise && !cs_high && !cs_fall
    && bit_cnt_reg != LAST_BIT
    |=> shift_a_reg == {$past(shift_a_reg[RES_W-2:0]), 1'b0})
    else $error("serial shift wrong");
endmodule : arb_readback

// *** dv/arb_host.sv ***
// host controller model: strobes, serial clock, data capture
`timescale 1ns/100ps
module arb_host (
  input  wire logic        CLK,
  input  wire logic [15:0] BUS,
  input  wire logic        BUS_OE_N,
  input  wire logic        FLAG,
  input  wire logic        SER_P,
  input  wire logic        SER_S,
  input  wire logic        SER_OE_N,
  output logic             CS_N,
  output logic             RD_SCLK
);
  initial begin
    CS_N    = 1'b1;
    RD_SCLK = 1'b1;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge CLK);
  endtask : gap

  // ==========================================================
  // frame: select apart from strobe, held low throughout
  task automatic frame_open(input logic idle);
    RD_SCLK = idle;
    gap(4);
    CS_N = 1'b0;
    gap(8);
  endtask : frame_open

  task automatic frame_close;
    CS_N = 1'b1;
    gap(8);
    RD_SCLK = 1'b1;
    gap(4);
  endtask : frame_close

  // ==========================================================
  // one strobe; a released bus reads inverted
  task automatic par_read(output logic [15:0] d, output logic f);
    RD_SCLK = 1'b0;
    gap(6);
    d = (BUS_OE_N === 1'b0) ? BUS : ~BUS;
    f = FLAG;
    RD_SCLK = 1'b1;
    gap(6);
  endtask : par_read

  // ==========================================================
  // sixteen clocks, bit taken while low before each rise
  task automatic ser_word(output logic [15:0] p, output logic [15:0] s,
                          output logic f);
    f = FLAG;
    for (int i = 0; i < 16; i++) begin
      p = {p[14:0], (SER_OE_N === 1'b0) ? SER_P : ~SER_P};
      s = {s[14:0], (SER_OE_N === 1'b0) ? SER_S : ~SER_S};
      RD_SCLK = 1'b1;
      gap(4);
      RD_SCLK = 1'b0;
      gap(4);
    end
  endtask : ser_word
endmodule : arb_host

// *** dv/testbench.sv ***
// self-checking bench for the readback port
`timescale 1ns/100ps
module testbench;
  localparam int BASE = 10;
  logic         clk;
  logic         rst;
  logic         cs_n;
  logic         rd_sclk;
  logic         if_sel;
  logic         byte_sel;
  logic         hbf;
  logic [2:0]   os_sel;
  logic         trig1;
  logic         trig2;
  logic [127:0] res;
  logic         busy;
  logic [2:0]   oversampling_ratio;
  logic         flag;
  logic [15:0]  bus;
  logic         bus_oe_n;
  logic         sp;
  logic         ss;
  logic         s_oe_n;
  logic [15:0]  d;
  logic [15:0]  e;
  logic         f;
  int           failures = 0;
  int           check_count = 0;
  int           cycles = 0;

  arb_readback #(.BASE_CONV_CYCLES(BASE)) arb_readback_i (
    .CLK(clk), .RST(rst), .CS_N(cs_n), .RD_SCLK(rd_sclk),
    .INTERFACE_SELECT(if_sel), .BYTE_MODE_SELECT(byte_sel),
    .HIGH_BYTE_FIRST_SELECT(hbf), .OVERSAMPLING_RATIO_SELECT(os_sel),
    .SAMPLE_TRIGGER_GROUP1(trig1), .SAMPLE_TRIGGER_GROUP2(trig2),
    .RESULT_DATA(res), .BUSY(busy), .OVERSAMPLING_RATIO(oversampling_ratio),
    .FIRST_CHANNEL_FLAG(flag), .PARALLEL_OUT_BUS(bus),
    .PARALLEL_OUT_BUS_OE_N(bus_oe_n), .SERIAL_OUT_PRIMARY(sp),
    .SERIAL_OUT_SECONDARY(ss), .SERIAL_OUT_OE_N(s_oe_n));

  arb_host arb_host_i (
    .CLK(clk), .BUS(bus), .BUS_OE_N(bus_oe_n), .FLAG(flag), .SER_P(sp),
    .SER_S(ss), .SER_OE_N(s_oe_n), .CS_N(cs_n), .RD_SCLK(rd_sclk));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [15:0] word(input logic [3:0] s, input int c);
    return {4'h9, s, 4'h6, 4'(c)};
  endfunction : word

  task automatic load(input logic [3:0] s);
    for (int c = 0; c < 8; c++) res[16*c +: 16] = word(s, c + 1);
  endtask : load

  task automatic check(input string n, input logic [15:0] x,
                       input logic [15:0] y);
    check_count++;
    if (y !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, x, y);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // trigger, then measure the busy pulse
  task automatic convert(input logic g1, input logic g2, input int len);
    int n;
    n = 0;
    trig1 = g1;
    trig2 = g2;
    for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk);
    check("busy_rise", 16'h0001, {15'h0000, busy});
    trig1 = 1'b0;
    trig2 = 1'b0;
    while (busy === 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check("busy_len", 16'(len), 16'(n));
  endtask : convert

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    if_sel = 1'b0;
    byte_sel = 1'b0;
    hbf = 1'b0;
    os_sel = 3'h0;
    trig1 = 1'b0;
    trig2 = 1'b0;
    load(4'h1);
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("reset_oe", 16'h0001, {15'h0000, bus_oe_n});
    check("reset_flag", 16'h0000, {15'h0000, flag});
    for (int r = 1; r <= 11; r++) begin
      os_sel = 3'(r % 8);
      convert(1'b1, 1'b1, BASE << ((r - 1) % 8));
      check("ratio", 16'(r % 8), {13'h0000, oversampling_ratio});
    end
    arb_host_i.frame_open(1'b1);
    for (int c = 1; c <= 9; c++) begin
      arb_host_i.par_read(d, f);
      check("par_word", word(4'h1, (c - 1) % 8 + 1), d);
      check("par_flag", {15'h0000, c == 1}, {15'h0000, f});
    end
    arb_host_i.frame_close();
    check("par_float", 16'h0001, {15'h0000, bus_oe_n});
    load(4'h2);
    os_sel = 3'h0;
    fork
      convert(1'b1, 1'b1, BASE << 3);
      begin
        repeat (10) @(negedge clk);
        arb_host_i.frame_open(1'b1);
        arb_host_i.par_read(d, f);
        check("busy_read", word(4'h1, 1), d);
        arb_host_i.frame_close();
      end
    join
    arb_host_i.frame_open(1'b1);
    arb_host_i.par_read(d, f);
    check("new_read", word(4'h2, 1), d);
    arb_host_i.frame_close();
    if_sel = 1'b1;
    byte_sel = 1'b1;
    for (int h = 0; h < 2; h++) begin
      hbf = h[0];
      repeat (4) @(negedge clk);
      arb_host_i.frame_open(1'b1);
      for (int k = 0; k < 4; k++) begin
        arb_host_i.par_read(d, f);
        e = word(4'h2, k / 2 + 1);
        check("byte", {8'h00, (k % 2 == h) ? e[7:0] : e[15:8]}, d);
        check("byte_flag", {15'h0000, k < 2}, {15'h0000, f});
      end
      arb_host_i.frame_close();
    end
    byte_sel = 1'b0;
    repeat (4) @(negedge clk);
    arb_host_i.frame_open(1'b0);
    for (int c = 1; c <= 8; c++) begin
      arb_host_i.ser_word(d, e, f);
      check("ser_pri", word(4'h2, c), d);
      check("ser_sec", word(4'h2, (c + 3) % 8 + 1), e);
      check("ser_flag", {15'h0000, c == 1}, {15'h0000, f});
    end
    arb_host_i.frame_close();
    check("ser_float", 16'h0001, {15'h0000, s_oe_n});
    convert(1'b0, 1'b1, BASE);
    final_report();
  end
endmodule : testbench
